/* dv/vectored_interrupt_controller_bench.sv */
// Self-checking bench: controller, core model, queue-based winner model.
// Assumes the design, package and core model are compiled first.
`timescale 1ns/10ps
module vectored_interrupt_controller_bench;
   import vic_pkg::*;
   logic        ref_clk, rst_n, vtor_load, mask_enable, core_ack, core_done;
   logic        clk_en;
   logic [31:0] periph;
   logic [39:0] gpio_in, gpio_hi;
   logic [79:0] gpio_sense;
   logic [31:0] en, vtor, sw_set, sw_clear, pending, s;
   logic [63:0] irq_prio;
   logic [3:0]  exc_req;
   vic_prio_t   prio_mask;
   vic_grant_t  grant;
   int          failures, tests_run, cyc, k, pr[32], pq[$];
   vic_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
      .gpio_in(gpio_in), .gpio_sense(gpio_sense), .gpio_active_high(gpio_hi),
      .periph_req(periph), .exc_req(exc_req), .irq_enable(en),
      .irq_prio(irq_prio), .prio_mask(prio_mask), .mask_enable(mask_enable),
      .vtor(vtor), .vtor_load(vtor_load), .sw_set(sw_set),
      .sw_clear(sw_clear), .core_ack(core_ack), .core_done(core_done),
      .grant(grant), .pending(pending), .gpio_irq(), .irq_out());
   vic_core_model core (.ref_clk(ref_clk), .rst_n(rst_n), .grant(grant),
      .core_ack(core_ack), .core_done(core_done));
   initial begin
      ref_clk = 1'h0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic check(input string nm, input int e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Wait for the edge at which the core takes a grant
   task automatic take(input int n);
      int t;
      t = 0;
      do begin
         @(negedge ref_clk);
         t++;
      end while (!(grant.valid === 1'h1 && core_ack === 1'h1) && t < 60);
      check("number", n, {26'h0, grant.number});
      check("addr", {vtor[31:7], 7'h00} + 4 * n, grant.addr);
      @(posedge ref_clk);
   endtask
   task automatic flush();
      en <= 32'h0;
      repeat (12) @(posedge ref_clk);
      sw_clear <= 32'hFFFFFFFF;
      @(posedge ref_clk);
      sw_clear <= 32'h0;
      en <= 32'hFFFFFFFF;
   endtask
   function automatic int best();
      int b;
      b = -1;
      foreach (pq[i])
         if (!(mask_enable && pr[pq[i]] >= prio_mask) && (b < 0
             || pr[pq[i]] < pr[b] || pr[pq[i]] == pr[b] && pq[i] < b))
            b = pq[i];
      return b;
   endfunction
   initial begin
      {rst_n, vtor_load, mask_enable, prio_mask, exc_req} = '0;
      {gpio_in, gpio_sense, sw_set, sw_clear} = '0;
      gpio_hi = 40'hFFFFFFFFFF;
      en = 32'hFFFFFFFF;
      clk_en = 1'h1;
      periph = 32'h0;
      vtor = 32'h00001000;
      void'($urandom(12));
      foreach (pr[i]) pr[i] = $urandom_range(3);
      foreach (pr[i]) irq_prio[2*i +: 2] = 2'(pr[i]);
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'h1;
      for (int r = 0; r < 6; r++) begin
         @(posedge ref_clk);
         mask_enable <= r[0];
         prio_mask <= 2'(1 + r % 3);
         vtor_load <= 1'h1;
         if (r == 4) vtor <= 32'h000200A5;
         @(posedge ref_clk);
         vtor_load <= 1'h0;
         exc_req <= (r < 4) ? 4'h1 << r : 4'h0;
         s = 0;
         repeat (3) begin
            k = $urandom_range(31);
            s[k] = 1'h1;
            pq.push_back(k);
         end
         @(posedge ref_clk);
         sw_set <= s;
         @(posedge ref_clk);
         sw_set <= 32'h0;
         if (r < 4) take(r);
         exc_req <= 4'h0;
         for (int b = best(); b >= 0; b = best()) begin
            take(16 + b);
            pq = pq.find(x) with (x != b);
         end
         s = 0;
         foreach (pq[i]) s[pq[i]] = 1'h1;
         @(negedge ref_clk);
         check("held", s, pending);
         flush();
         pq = {};
         $display("round %0d done", r);
      end
      mask_enable <= 1'h0;
      for (int j = 0; j < 8; j++) begin
         k = (j < 4) ? 0 : 12;
         @(posedge ref_clk);
         gpio_sense[2*k +: 2] <= 2'(j % 4);
         @(posedge ref_clk);
         gpio_in[k] <= 1'h1;
         if (j % 4 == 2) begin
            repeat (3) @(posedge ref_clk);
            gpio_in[k] <= 1'h0;
         end
         take(16 + k);
         gpio_in[k] <= 1'h0;
         flush();
         $display("pin test %0d done", j);
      end
      @(posedge ref_clk);
      clk_en <= 1'h0;
      sw_set <= 32'h00000100;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      check("frozen", 0, pending);
      k = 13 + $urandom_range(18);
      @(posedge ref_clk);
      clk_en <= 1'h1;
      sw_set <= 32'h0;
      periph[k] <= 1'h1;
      take(16 + k);
      periph[k] <= 1'h0;
      flush();
      $display("freeze and peripheral tests done");
      print_verdict();
   end
endmodule

/* dv/vic_core_model.sv */
// Core model: takes offered grants, runs a handler of random length.
// Assumes grant is registered on ref_clk.
`timescale 1ns/10ps
module vic_core_model (
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   input  wire vic_pkg::vic_grant_t grant,
   output logic                     core_ack,
   output logic                     core_done
);
   import vic_pkg::*;
   int n;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_ack  <= 1'h0;
         core_done <= 1'h0;
         n         <= 0;
      end else begin
         core_done <= n == 1;
         if (n > 0) n <= n - 1;
         // Pulsed for one cycle when a valid grant is seen and no handler runs
         core_ack <= grant.valid && n == 0 && !core_ack;
         if (core_ack && grant.valid) n <= 2 + $urandom_range(3);
      end
   end
endmodule

/* dv/vic_top_checker.sv */
// Port assertions for the interrupt controller top.
// Assumes one clock domain; bound to every vic_top instance.
`timescale 1ns/10ps
`include "vic_cfg.svh"
module vic_top_checker (
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   input  wire logic                clk_en,
   input  wire logic [39:0]         gpio_in,
   input  wire logic [79:0]         gpio_sense,
   input  wire logic [39:0]         gpio_active_high,
   input  wire logic [3:0]          exc_req,
   input  wire vic_pkg::vic_prio_t  prio_mask,
   input  wire logic                mask_enable,
   input  wire logic [31:0]         vtor,
   input  wire vic_pkg::vic_grant_t grant,
   input  wire logic [39:0]         gpio_irq,
   input  wire logic                irq_out
);
   import vic_pkg::*;
   logic [1:0] s0;
   assign s0 = gpio_sense[1:0];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_pin;
      clk_en && (s0 == `VIC_SENSE_LEVEL && gpio_in[0] == gpio_active_high[0]
      || s0 == `VIC_SENSE_RISE && $rose(gpio_in[0])
      || s0 == `VIC_SENSE_FALL && $fell(gpio_in[0])
      || s0 == `VIC_SENSE_BOTH && $changed(gpio_in[0])) |=> gpio_irq[0];
   endproperty
   AST_NUM: assert property (grant.valid |-> grant.number < 6'h30)
      else $error("vector number out of range");
   AST_MASK: assert property (grant.valid && grant.number > 6'h0F
      && $past(mask_enable) |-> grant.prio < $past(prio_mask))
      else $error("masked level granted");
   AST_ADDR: assert property (grant.valid |-> grant.addr ==
      {vtor[31:7], 7'h00} + {24'h0, grant.number, 2'h0})
      else $error("vector address wrong");
   AST_EXC: assert property (grant.valid && grant.number < 6'h10 |->
      grant.number < 6'h04 && grant.prio == 2'h0 && $past(exc_req) != 4'h0)
      else $error("bad exception grant");
   AST_OUT: assert property (irq_out == grant.valid)
      else $error("request line differs from valid");
   AST_PIN: assert property (p_pin)
      else $error("pin event missed");
   cover property (grant.valid && grant.number < 6'h04);
   cover property (grant.valid && mask_enable);
   cover property (gpio_irq[0] ##2 grant.valid);
endmodule
bind vic_top vic_top_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .clk_en(clk_en), .gpio_in(gpio_in), .gpio_sense(gpio_sense),
   .gpio_active_high(gpio_active_high), .exc_req(exc_req),
   .prio_mask(prio_mask), .mask_enable(mask_enable), .vtor(vtor),
   .grant(grant), .gpio_irq(gpio_irq), .irq_out(irq_out));

/* logic/vic_cfg.svh */
// Constants for the vectored interrupt controller: sizes, codes, resets.
// Assumes inclusion by the package and the design files.
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH
`define VIC_NUM_IRQ      32
`define VIC_NUM_PIN_IRQ  13
`define VIC_NUM_GPIO     40
`define VIC_NUM_EXC      4
`define VIC_PRIO_W       2
`define VIC_SENSE_LEVEL  2'h0
`define VIC_SENSE_RISE   2'h1
`define VIC_SENSE_FALL   2'h2
`define VIC_SENSE_BOTH   2'h3
`define VIC_VTOR_RESET   32'h00000000
`define VIC_VEC_STRIDE   32'h00000004
`define VIC_EXC_BASE     6'h00
`define VIC_IRQ_BASE     6'h10
`endif

/* logic/vic_pin_sense.sv */
// One pin's level/edge detector; on pins below 13 it also feeds a controller request.
// Assumes pin input is synchronous to ref_clk.
`timescale 1ns/10ps
`include "vic_cfg.svh"
module vic_pin_sense (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              clk_en,
   input  wire vic_pkg::vic_sense_t sense,
   input  wire logic              active_high,
   input  wire logic              pin,
   output logic                   hit
);
   import vic_pkg::*;
   logic prev;
   wire  lvl  = pin ~^ active_high;
   wire  rise = pin & ~prev;
   wire  fall = ~pin & prev;
   wire  next_hit = (sense == `VIC_SENSE_LEVEL) ? lvl :
                    (sense == `VIC_SENSE_RISE)  ? rise :
                    (sense == `VIC_SENSE_FALL)  ? fall : (rise | fall);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev <= 1'b0;
         hit  <= 1'b0;
      end else if (clk_en) begin
         prev <= pin;
         hit  <= next_hit;
      end
   end
endmodule

/* logic/vic_pkg.sv */
// Types shared by the vectored interrupt controller files.
// Assumes vic_cfg.svh defines the sizes.
`include "vic_cfg.svh"
package vic_pkg;
   typedef logic [`VIC_PRIO_W-1:0] vic_prio_t;
   typedef logic [1:0]             vic_sense_t;
   typedef struct packed {
      logic        valid;
      logic [5:0]  number;
      vic_prio_t   prio;
      logic [31:0] addr;
   } vic_grant_t;
   typedef enum logic [2:0] {
      VIC_IDLE   = 3'b001,
      VIC_OFFER  = 3'b010,
      VIC_ACTIVE = 3'b100
   } vic_state_t;
endpackage

/* logic/vic_top.sv */
// Vectored interrupt controller: gathers requests, grants one to the core.
// Assumes synchronous inputs; configuration comes as plain inputs.
`timescale 1ns/10ps
`include "vic_cfg.svh"
module vic_top (
   input  wire logic                         ref_clk,
   input  wire logic                         rst_n,
   input  wire logic                         clk_en,
   input  wire logic [`VIC_NUM_GPIO-1:0]     gpio_in,
   input  wire logic [2*`VIC_NUM_GPIO-1:0]   gpio_sense,
   input  wire logic [`VIC_NUM_GPIO-1:0]     gpio_active_high,
   input  wire logic [`VIC_NUM_IRQ-1:0]      periph_req,
   input  wire logic [`VIC_NUM_EXC-1:0]      exc_req,
   input  wire logic [`VIC_NUM_IRQ-1:0]      irq_enable,
   input  wire logic [2*`VIC_NUM_IRQ-1:0]    irq_prio,
   input  wire vic_pkg::vic_prio_t           prio_mask,
   input  wire logic                         mask_enable,
   input  wire logic [31:0]                  vtor,
   input  wire logic                         vtor_load,
   input  wire logic [`VIC_NUM_IRQ-1:0]      sw_set,
   input  wire logic [`VIC_NUM_IRQ-1:0]      sw_clear,
   input  wire logic                         core_ack,
   input  wire logic                         core_done,
   output vic_pkg::vic_grant_t               grant,
   output logic [`VIC_NUM_IRQ-1:0]           pending,
   output logic [`VIC_NUM_GPIO-1:0]          gpio_irq,
   output logic                              irq_out
);
   import vic_pkg::*;

   logic [31:0]             vec_base;
   logic [`VIC_NUM_IRQ-1:0] pend;
   vic_state_t              state;
   logic [5:0]              cur_num;

   // Per-pin detection on every gpio pin
   genvar g;
   generate
      for (g = 0; g < `VIC_NUM_GPIO; g++) begin : g_pin
         vic_pin_sense u_sense (
            .ref_clk     (ref_clk),
            .rst_n       (rst_n),
            .clk_en      (clk_en),
            .sense       (gpio_sense[2*g +: 2]),
            .active_high (gpio_active_high[g]),
            .pin         (gpio_in[g]),
            .hit         (gpio_irq[g])
         );
      end
   endgenerate

   // Low inputs come from pins, the rest from peripherals
   wire [`VIC_NUM_IRQ-1:0] hw_req;
   genvar r;
   generate
      for (r = 0; r < `VIC_NUM_IRQ; r++) begin : g_src
         if (r < `VIC_NUM_PIN_IRQ) begin : g_from_pin
            // Pin-owned input: the peripheral bit is ignored
            assign hw_req[r] = gpio_irq[r];
         end else begin : g_from_periph
            // One combined line per peripheral
            assign hw_req[r] = periph_req[r];
         end
      end
   endgenerate

   function automatic vic_prio_t prio_of(input logic [5:0] n);
      prio_of = irq_prio[2*n[4:0] +: 2];
   endfunction

   // Eligible: enabled, pending, above mask (lower value is more urgent)
   function automatic logic eligible(input logic [5:0] n);
      eligible = pend[n[4:0]] & irq_enable[n[4:0]] &
                 (!mask_enable || (prio_of(n) < prio_mask));
   endfunction

   logic [5:0] best_num;
   vic_prio_t  best_prio;
   logic       best_ok;
   // Scan downwards so the lowest number wins any tie
   always_comb begin
      best_num  = 6'h00;
      best_prio = 2'h3;
      best_ok   = 1'b0;
      for (int i = `VIC_NUM_IRQ-1; i >= 0; i--) begin
         if (eligible(6'(i)) &&
             (!best_ok || prio_of(6'(i)) <= best_prio)) begin
            best_num  = 6'(i);
            best_prio = prio_of(6'(i));
            best_ok   = 1'b1;
         end
      end
   end

   // Exceptions take the lowest vectors and beat any interrupt
   logic [5:0] exc_num;
   logic       exc_ok;
   always_comb begin
      exc_num = 6'h00;
      exc_ok  = 1'b0;
      for (int i = `VIC_NUM_EXC-1; i >= 0; i--) begin
         if (exc_req[i]) begin
            exc_num = 6'(i);
            exc_ok  = 1'b1;
         end
      end
   end

   wire [5:0] win_num = exc_ok ? (`VIC_EXC_BASE + exc_num)
                               : (`VIC_IRQ_BASE + best_num);
   wire       win_ok  = exc_ok | best_ok;

   // Vector slot address: base plus one word per vector
   function automatic logic [31:0] vec_addr(input logic [31:0] base,
                                            input logic [5:0]  num);
      vec_addr = base + (32'(num) * `VIC_VEC_STRIDE);
   endfunction

   wire [31:0] win_addr = vec_addr(vec_base, win_num);

   // Idle until a winner, offered until taken or no winner remains, active until done
   vic_state_t next_state;
   always_comb begin
      case (state)
         VIC_IDLE:   next_state = win_ok ? VIC_OFFER : VIC_IDLE;
         VIC_OFFER:  next_state = core_ack ? VIC_ACTIVE :
                                  (win_ok ? VIC_OFFER : VIC_IDLE);
         VIC_ACTIVE: next_state = core_done ? VIC_IDLE : VIC_ACTIVE;
         default:    next_state = VIC_IDLE;
      endcase
   end

   // Only interrupts clear a flag when taken; exceptions are levels
   wire taken = (state == VIC_OFFER) && core_ack &&
                (grant.number >= `VIC_IRQ_BASE);
   wire [`VIC_NUM_IRQ-1:0] take_clr =
      taken ? (32'h00000001 << cur_num[4:0]) : 32'h00000000;

   // Low seven bits of the base always read as zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         vec_base <= `VIC_VTOR_RESET;
      end else if (clk_en && vtor_load) begin
         vec_base <= {vtor[31:7], 7'h00};
      end
   end

   // Set wins over any clear in the same cycle
   wire [`VIC_NUM_IRQ-1:0] next_pend =
      (pend & ~(sw_clear | take_clr)) | sw_set | hw_req;

   // One flag per input
   genvar q;
   generate
      for (q = 0; q < `VIC_NUM_IRQ; q++) begin : g_pend
         logic flag;
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               flag <= 1'b0;
            end else if (clk_en) begin
               flag <= next_pend[q];
            end
         end
         assign pend[q] = flag;
      end
   endgenerate

   // Offer stays open until the core takes it; frozen while served
   wire       offer_open = (state != VIC_ACTIVE) &&
                           !(state == VIC_OFFER && core_ack);
   wire [5:0] next_cur   = exc_ok ? exc_num : best_num;
   // Exceptions report the most urgent level
   wire [`VIC_PRIO_W-1:0] win_prio = exc_ok ? 2'h0 : best_prio;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= VIC_IDLE;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_num <= 6'h00;
      end else if (clk_en && offer_open) begin
         cur_num <= next_cur;
      end
   end

   // Shows the flags as they stand after this edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pending <= 32'h00000000;
      end else if (clk_en) begin
         pending <= next_pend;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         grant   <= '0;
         irq_out <= 1'b0;
      end else if (clk_en) begin
         if (offer_open) begin
            grant.valid  <= win_ok;
            grant.number <= win_num;
            grant.prio   <= win_prio;
            grant.addr   <= win_addr;
            irq_out      <= win_ok;
         end else begin
            grant.valid <= 1'b0;
            irq_out     <= 1'b0;
         end
      end
   end
endmodule
